/* rtl/gsml_spi_master.sv */
/*
  GPIO SPI master with internal loopback, an APB slave for software.
  Holds the register file, the serial shift engine and the pin drive.
  Assumes an APB master on pclk, an SPI slave on the pins and a pad
  ring that resolves pin levels from the output enables.
*/
// Register access over APB and the register addresses were left to the implementer.
// Overview of operation
// RULE1 - Pins act as SPI master only while SPI enable is one.
// RULE2 - Device generates the serial clock and times transfers by it.
// RULE3 - Outgoing data drives MOSI; incoming data is taken from MISO.
// RULE4 - Slave select is driven during transfers at software level.
// RULE5 - Polarity chooses inverted or non-inverted idle serial clock.
// RULE6 - Phase chooses sampling on first or second edge of a bit.
// RULE7 - Five-bit length field sets one to twenty-four bits per transfer.
// RULE8 - Three transmit bytes; first is least, third most significant.
// RULE9 - Execute write 0x01 drives select low and starts a transfer.
// RULE10 - Execute write 0x02 releases select high, starts nothing.
// RULE11 - Software writes: configure, load, start selected, wait, deselect.
// RULE12 - Received bits appear in three receive bytes before deselect.
// RULE13 - Loopback routes transmit data internally to the data input.
// RULE14 - During loopback all external pins hold their last state.
// RULE15 - Loopback ends with transmit bytes captured as receive bytes.
// RULE16 - Select pin freezes at its level when loopback was enabled.
// RULE17 - Loopback transfers are programmed and run as normal ones.
// RULE18 - Software sets polarity and phase before loopback, not during.
// RULE19 - Go bit reads zero again once all bits have shifted.
`timescale 1ns/10ps
`include "gsml_map.svh"

module gsml_spi_master (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output      logic [31:0]      prdata,
  output      logic             pready,
  output      logic             pslverr,
  input  wire logic             spi_miso_i,
  output      gsml_pkg::gsml_pins_t spi_pin_o,
  output      gsml_pkg::gsml_pins_t spi_pin_oe
);

  localparam logic [2:0] HALF_LAST =
    3'(`GSML_SCLK_HALF_CYC - 1);

  gsml_pkg::gsml_state_t s_q;
  gsml_pkg::gsml_state_t s_d;

  logic        hit;
  logic        wr;
  logic        rd_setup;
  logic        go_wr;
  logic [4:0]  n_eff;
  logic [23:0] sh_load;
  logic [5:0]  last_edge;
  logic        sample;
  logic        miso_in;
  logic [23:0] shin_nx;
  logic [31:0] rdata;

  // Decode
  always_comb
  begin
    hit = 1'b1;
    if (paddr == `GSML_A_PINCFG)
      hit = 1'b1;
    else if (paddr == `GSML_A_FMT)
      hit = 1'b1;
    else if (paddr == `GSML_A_TX_LOW)
      hit = 1'b1;
    else if (paddr == `GSML_A_TX_MID)
      hit = 1'b1;
    else if (paddr == `GSML_A_TX_HIGH)
      hit = 1'b1;
    else if (paddr == `GSML_A_RX_LOW)
      hit = 1'b1;
    else if (paddr == `GSML_A_RX_MID)
      hit = 1'b1;
    else if (paddr == `GSML_A_RX_HIGH)
      hit = 1'b1;
    else if (paddr == `GSML_A_EXE)
      hit = 1'b1;
    else if (paddr == `GSML_A_DIAG)
      hit = 1'b1;
    else
      hit = 1'b0;
  end

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign wr       = psel & penable & pwrite & hit & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign go_wr    = wr && (paddr == `GSML_A_EXE)
                    && pwdata[`GSML_F_GO];

  // Read mux, captured in the setup phase so prdata is a flop
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (paddr == `GSML_A_PINCFG)
      rdata[`GSML_F_SPI_EN] = s_q.spi_en;
    else if (paddr == `GSML_A_FMT)
    begin
      rdata[`GSML_F_CPOL] = s_q.cpol;
      rdata[`GSML_F_CPHA] = s_q.cpha;
      rdata[`GSML_F_LEN_HI:`GSML_F_LEN_LO] = s_q.len;
    end
    else if (paddr == `GSML_A_TX_LOW)
      rdata[7:0] = s_q.tx[7:0];
    else if (paddr == `GSML_A_TX_MID)
      rdata[7:0] = s_q.tx[15:8];
    else if (paddr == `GSML_A_TX_HIGH)
      rdata[7:0] = s_q.tx[23:16];
    else if (paddr == `GSML_A_RX_LOW)
      rdata[7:0] = s_q.rx[7:0];                           // RULE12
    else if (paddr == `GSML_A_RX_MID)
      rdata[7:0] = s_q.rx[15:8];
    else if (paddr == `GSML_A_RX_HIGH)
      rdata[7:0] = s_q.rx[23:16];
    else if (paddr == `GSML_A_EXE)
    begin
      rdata[`GSML_F_GO] = (s_q.fsm == gsml_pkg::GSML_RUN); // RULE19
      rdata[`GSML_F_SS] = s_q.ss_ctrl;
    end
    else if (paddr == `GSML_A_DIAG)
      rdata[`GSML_F_LOOP] = s_q.loopback;
  end

  // Length 0 runs one bit, above 24 runs 24
  always_comb
  begin
    if (s_q.len == 5'h00)
      n_eff = 5'h01;
    else if (s_q.len > `GSML_MAX_BITS)
      n_eff = `GSML_MAX_BITS;                             // RULE7
    else
      n_eff = s_q.len;
  end

  // MSB of the word sits at bit 23 of the shifter
  assign sh_load   = s_q.tx << (`GSML_MAX_BITS - n_eff);  // RULE8
  assign last_edge = 6'({s_q.nbits, 1'b0} - 6'h01);
  // Odd edge index is trailing
  assign sample    = s_q.cpha_l ? s_q.edges[0] : ~s_q.edges[0]; // RULE6
  // Loopback feeds the shifted-out bit straight back
  assign miso_in   = s_q.loopback ? s_q.mosi : s_q.miso_s2; // RULE13
  assign shin_nx   = {s_q.shin[22:0], miso_in};           // RULE3

  always_comb
  begin
    s_d = s_q;
    s_d.miso_s1 = spi_miso_i;
    s_d.miso_s2 = s_q.miso_s1;
    if (rd_setup)
      s_d.prdata = rdata;

    if (wr)
    begin
      if (paddr == `GSML_A_PINCFG)
        s_d.spi_en = pwdata[`GSML_F_SPI_EN];
      else if (paddr == `GSML_A_FMT)
      begin
        s_d.cpol = pwdata[`GSML_F_CPOL];                  // RULE5
        s_d.cpha = pwdata[`GSML_F_CPHA];
        s_d.len  = pwdata[`GSML_F_LEN_HI:`GSML_F_LEN_LO]; // RULE7
      end
      else if (paddr == `GSML_A_TX_LOW)
        s_d.tx[7:0] = pwdata[7:0];                        // RULE8
      else if (paddr == `GSML_A_TX_MID)
        s_d.tx[15:8] = pwdata[7:0];
      else if (paddr == `GSML_A_TX_HIGH)
        s_d.tx[23:16] = pwdata[7:0];
      else if (paddr == `GSML_A_EXE)
        s_d.ss_ctrl = pwdata[`GSML_F_SS];                 // RULE9 RULE10
      else if (paddr == `GSML_A_DIAG)
        s_d.loopback = pwdata[`GSML_F_LOOP];
    end

    case (s_q.fsm)
      gsml_pkg::GSML_IDLE:
      begin
        // Same start path in loopback and normal mode
        if (go_wr)                                         // RULE9 RULE17
        begin
          s_d.fsm    = gsml_pkg::GSML_RUN;
          s_d.cpha_l = s_q.cpha;
          s_d.nbits  = n_eff;
          s_d.div    = 3'h0;
          s_d.edges  = 6'h00;
          s_d.phase  = 1'b0;
          s_d.shin   = 24'h00_0000;
          s_d.shout  = sh_load;
          // Phase 0 puts the first bit out before the first edge
          if (!s_q.cpha)
          begin
            s_d.mosi  = sh_load[23];
            s_d.shout = {sh_load[22:0], 1'b0};
          end
        end
      end
      gsml_pkg::GSML_RUN:
      begin
        s_d.div = 3'(s_q.div + 3'h1);
        if (s_q.div == HALF_LAST)                          // RULE2
        begin
          s_d.div   = 3'h0;
          s_d.phase = ~s_q.phase;
          s_d.edges = 6'(s_q.edges + 6'h01);
          if (sample)
            s_d.shin = shin_nx;
          else
          begin
            s_d.mosi  = s_q.shout[23];                    // RULE3
            s_d.shout = {s_q.shout[22:0], 1'b0};
          end
          if (s_q.edges == last_edge)
          begin
            s_d.fsm = gsml_pkg::GSML_IDLE;                 // RULE19
            // Result right-aligned in the receive bytes
            s_d.rx  = sample ? shin_nx : s_q.shin;        // RULE12 RULE15
          end
        end
      end
      default:
        s_d.fsm = gsml_pkg::GSML_IDLE;
    endcase

    // Pins only follow the engine outside loopback, which also
    // keeps select at its level from the moment loopback began.
    // Changing polarity in loopback thus cannot reach the pads.
    if (!s_d.loopback)                                     // RULE14 RULE16 RULE18
    begin
      s_d.pins.sclk = s_d.cpol ^ s_d.phase;               // RULE5
      s_d.pins.mosi = s_d.mosi;
      s_d.pins.ss_n = s_d.ss_ctrl;                        // RULE4
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.len       <= `GSML_R_LEN;
      s_q.ss_ctrl   <= `GSML_R_SS;
      s_q.pins.ss_n <= `GSML_R_SS;
      s_q.fsm       <= gsml_pkg::GSML_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign prdata    = s_q.prdata;
  assign spi_pin_o = s_q.pins;
  // MISO is never driven; the other three only while enabled
  assign spi_pin_oe.sclk = s_q.spi_en;                    // RULE1
  assign spi_pin_oe.mosi = s_q.spi_en;
  assign spi_pin_oe.ss_n = s_q.spi_en;

endmodule

/* rtl/gsml_map.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the GPIO SPI master with loopback.
  Assumes an 8-bit APB byte address and a 100 MHz pclk.
*/
`ifndef GSML_MAP_SVH
`define GSML_MAP_SVH

// Byte offsets, one aligned 32-bit word each
`define GSML_A_PINCFG   8'h00
`define GSML_A_FMT      8'h04
`define GSML_A_TX_LOW   8'h08
`define GSML_A_TX_MID   8'h0c
`define GSML_A_TX_HIGH  8'h10
`define GSML_A_RX_LOW   8'h14
`define GSML_A_RX_MID   8'h18
`define GSML_A_RX_HIGH  8'h1c
`define GSML_A_EXE      8'h20
`define GSML_A_DIAG     8'h24

// Field positions
`define GSML_F_SPI_EN   0
`define GSML_F_CPOL     0
`define GSML_F_CPHA     1
`define GSML_F_LEN_LO   2
`define GSML_F_LEN_HI   6
`define GSML_F_GO       0
`define GSML_F_SS       1
`define GSML_F_LOOP     0

// Reset values and the transfer length limit
`define GSML_R_LEN      5'h00
`define GSML_R_SS       1'b1
`define GSML_MAX_BITS   5'h18

// Serial clock half period
`define GSML_CLK_NS       10
`define GSML_SCLK_HALF_NS 40
`define GSML_SCLK_HALF_CYC (`GSML_SCLK_HALF_NS / `GSML_CLK_NS)

`endif

/* rtl/gsml_pkg.sv */
/*
  Types of the GPIO SPI master: pin bundle, engine state and the
  single packed state record of the block.
  Assumes gsml_map.svh for all numeric values.
*/
package gsml_pkg;

  typedef enum logic {
    GSML_IDLE,
    GSML_RUN
  } gsml_fsm_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ss_n;
  } gsml_pins_t;

  typedef struct packed {
    logic       spi_en;
    logic       cpol;
    logic       cpha;
    logic [4:0] len;
    logic [23:0] tx;
    logic [23:0] rx;
    logic       ss_ctrl;
    logic       loopback;
    gsml_fsm_t  fsm;
    logic       cpha_l;
    logic [4:0] nbits;
    logic [2:0] div;
    logic [5:0] edges;
    logic       phase;
    logic [23:0] shout;
    logic [23:0] shin;
    logic       mosi;
    gsml_pins_t pins;
    logic       miso_s1;
    logic       miso_s2;
    logic [31:0] prdata;
  } gsml_state_t;

endpackage

/* testbench/gsml_checker.sv */
/* Port checker of the SPI master.
   Bound in by the bench, sees only the top ports. */
`timescale 1ns/10ps
module gsml_checker (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire gsml_pkg::gsml_pins_t spi_pin_o,
  input wire gsml_pkg::gsml_pins_t spi_pin_oe
);
  logic lp_q;
  wire  wr = psel && penable && pwrite && pstrb[0];
  wire  ex = wr && paddr == 8'h20;
  wire  en = wr && paddr == 8'h00;
  wire  sx = ex || wr && paddr == 8'h24;
  wire  ss = spi_pin_o.ss_n;
  // Loopback shadow: pads freeze while set
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) lp_q <= 1'h0;
    else if (wr && paddr == 8'h24) lp_q <= pwdata[0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_oe_follow:
    assert property (en |=> spi_pin_oe == {3{$past(pwdata[0])}})
      else $error("oe level");
  chk_oe_cause:
    assert property ($changed(spi_pin_oe) |-> $past(en)) else $error("oe");
  chk_ss_select:
    assert property (ex && pwdata[1:0] == 2'h1 && !lp_q |=> !ss)
      else $error("ss not low");
  chk_ss_release:
    assert property (ex && pwdata[1:0] == 2'h2 && !lp_q |=> ss)
      else $error("ss not high");
  chk_ss_cause:
    assert property ($changed(ss) |-> $past(sx)) else $error("ss moved");
  chk_loop_hold:
    assert property (lp_q && $past(lp_q) |-> $stable(spi_pin_o))
      else $error("pads moved");
  chk_sclk_half:
    assert property ($changed(spi_pin_o.sclk) |=>
      $stable(spi_pin_o.sclk)[*3]) else $error("sclk");
  chk_mosi_bit:
    assert property ($changed(spi_pin_o.mosi) |=>
      $stable(spi_pin_o.mosi)[*2]) else $error("mosi");
endmodule

/* testbench/gsml_slave_model.sv */
/* SPI slave on the pads: sends a word MSB first, collects MOSI.
   Assumes pad levels already resolved from the enables. */
`timescale 1ns/10ps
module gsml_slave_model (
  input  wire gsml_pkg::gsml_pins_t pins,
  input  wire logic                 cpol,
  input  wire logic                 cpha,
  input  wire logic [4:0]           n,
  input  wire logic [23:0]          word,
  output      logic                 miso,
  output      logic [23:0]          got
);
  int b;
  initial miso = 1'h0;
  // Released line must not keep the last bit
  always @(posedge pins.ss_n) miso = ~miso;
  always @(negedge pins.ss_n)
  begin
    got = '0;
    b = int'(n) - int'(!cpha);
    if (!cpha) miso = word[b];
  end
  always @(pins.sclk)
    if (!pins.ss_n)
    begin
      if ((pins.sclk != cpol) != cpha)
        got = {got[22:0], pins.mosi};
      else if (b > 0)
      begin
        b--;
        miso = word[b];
      end
    end
endmodule

/* testbench/gpio_spi_master_loopback_test.sv */
/* SPI master bench: APB tasks, slave model, sequences.
   Assumes design, checker and slave model compiled first. */
`timescale 1ns/10ps
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", s, e, g); end end
module gpio_spi_master_loopback_test;
  logic                 pclk, presetn, psel, penable, pwrite, err;
  logic                 pready, pslverr, spi_miso_i;
  logic [1:0]           md;
  logic [3:0]           pstrb;
  logic [4:0]           n;
  logic [7:0]           paddr;
  logic [23:0]          sw, got, mk, w, t;
  logic [31:0]          pwdata, prdata, r;
  gsml_pkg::gsml_pins_t spi_pin_o, spi_pin_oe, pad;
  int                   fails, tests_run;
  gsml_spi_master dut_u (.*);
  gsml_slave_model slv_u (.pins(pad), .cpol(md[0]), .cpha(md[1]),
    .n(n), .word(sw), .miso(spi_miso_i), .got(got));
  // Pull-up on select, pull-down on clock and data
  assign pad = spi_pin_o & spi_pin_oe | ~spi_pin_oe & 3'h1;
  initial forever #5 pclk = ~pclk;
  initial
  begin
    #100000;
    fails++;
    summarize;
  end
  task automatic summarize;
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, logic we, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= we;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic run(input logic s);
    for (int i = 0; i < 3; i++)
      bus(8'h08 + 8'(4 * i), 1'h1, 32'(t[8 * i +: 8]));
    bus(8'h20, 1'h1, 32'h1);
    bus(8'h20, 1'h0, 32'h0);
    `CHK("busy", 1'h1, r[0])
    repeat (100) if (r[0] === 1'h1) bus(8'h20, 1'h0, 32'h0);
    `CHK("done", 1'h0, r[0])
    for (int i = 0; i < 3; i++)
    begin
      bus(8'h14 + 8'(4 * i), 1'h0, 32'h0);
      w[8 * i +: 8] = r[7:0];
    end
    `CHK("ss", s, spi_pin_o.ss_n)
    bus(8'h20, 1'h1, 32'h2);
  endtask
  initial
  begin
    {pclk, psel, penable, pwrite, paddr, pwdata, md, n, sw, t} = '0;
    pstrb = 4'hf;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    bus(8'h20, 1'h0, 32'h0);
    `CHK("exe", 32'h2, r)
    bus(8'h28, 1'h0, 32'h0);
    `CHK("slverr", 1'h1, err)
    bus(8'h00, 1'h1, 32'h1);
    bus(8'h00, 1'h0, 32'h0);
    `CHK("oe", 3'h7, spi_pin_oe)
    for (int m = 0; m < 4; m++)
    begin
      md = 2'(m);
      n = (m == 3) ? 5'h18 : 5'(1 + 7 * m);
      sw = 24'ha5c3e1 + 24'(m);
      t = 24'h3c96d2 - 24'(m);
      mk = 24'((32'h1 << n) - 32'h1);
      bus(8'h04, 1'h1, {25'h0, n, md});
      // Pins update by the write edge itself; look once settled
      @(negedge pclk);
      `CHK("ss", 1'h1, spi_pin_o.ss_n)
      `CHK("idle", md[0], spi_pin_o.sclk)
      run(1'h0);
      `CHK("rx", sw & mk, w)
      `CHK("mosi", t & mk, got)
    end
    bus(8'h24, 1'h1, 32'h1);
    t = 24'h5a1e87;
    run(1'h1);
    `CHK("loop", t, w)
    bus(8'h24, 1'h1, 32'h0);
    summarize;
  end
endmodule
bind gsml_spi_master gsml_checker chk_u (.*);
